/* File: inc/ifd_defs.svh */
// Purpose: constants for the instruction field decoder
// Assumes: 16-bit instruction words, 32-bit datapath
// Notes: field positions and format codes shared by rtl and checks
// Contract
// [RULE_01] split each word into nibble fields; opcode picks which fields exist
// [RULE_02] operand meaning of m and n fields is chosen by opcode only
// [RULE_03] zero-operand format: all bits 15..0 are opcode, no fields extracted
// [RULE_04] md format: opcode 15..8, source base 7..4, disp 3..0, loads register zero
// [RULE_05] nd4 format: opcode 15..8, destination base 7..4, disp 3..0, stores register zero
// [RULE_06] indexed indirect destination address is n register plus register zero
// [RULE_07] multiply-accumulate uses m and n as post-incremented pointers into accumulator
// [RULE_08] multiply-accumulate n register is a source, never written back except increment
// [RULE_09] d12 branch: 12-bit displacement under 4-bit opcode added to program counter
// [RULE_10] displacements zero-extended then scaled by one, two or four per size
// [RULE_11] logic immediates zero-extended; move, add, compare-equal immediates sign-extended
// [RULE_12] trap immediate zero-extended and multiplied by four for vector offset
// [RULE_13] 8-bit immediate or displacement in 7..0; n register in 11..8
// [RULE_14] two-register formats: n in 11..8, m in 7..4
`ifndef IFD_DEFS_SVH
`define IFD_DEFS_SVH
`define IFD_N_HI 11
`define IFD_N_LO 8
`define IFD_M_HI 7
`define IFD_M_LO 4
`define IFD_D4_HI 3
`define IFD_D8_HI 7
`define IFD_D12_HI 11
`define IFD_NOP_WORD 16'h0009
`define IFD_MACW_MASK 16'hF00F
`define IFD_MACW_CODE 16'h400F
`define IFD_IDX_MASK 16'hF00F
`define IFD_IDX_CODE 16'h0006
`define IFD_PC_RST 32'h00000000
`endif

/* File: inc/ifd_pkg.sv */
// Purpose: types for the instruction field decoder
// Assumes: nothing beyond ifd_defs.svh
// Notes: format codes are one-hot for cheap checks
package ifd_pkg;
  typedef enum logic [10:0] {
    IFD_F_ZERO = 11'h001,
    IFD_F_NM = 11'h002,
    IFD_F_MD = 11'h004,
    IFD_F_ND4 = 11'h008,
    IFD_F_D = 11'h010,
    IFD_F_D12 = 11'h020,
    IFD_F_ND8 = 11'h040,
    IFD_F_I = 11'h080,
    IFD_F_NI = 11'h100,
    IFD_F_N = 11'h200,
    IFD_F_M = 11'h400
  } ifd_fmt_e;
  typedef enum logic [2:0] {
    IFD_X_ZERO = 3'h1,
    IFD_X_SIGN = 3'h2,
    IFD_X_TRAP = 3'h4
  } ifd_ext_e;
  typedef struct packed {
    logic valid;
    ifd_fmt_e fmt;
    logic [15:0] opcode;
    logic [3:0] rn;
    logic [3:0] rm;
    logic rn_used;
    logic rm_used;
    logic rn_write;
    logic dst_reg_zero;
    logic src_reg_zero;
    logic idx_r0;
    logic mac_ptrs;
    logic [31:0] imm;
    logic [31:0] disp;
    logic [31:0] branch_target;
  } ifd_state_s;
endpackage

/* File: rtl/ifd_decoder.sv */
// Purpose: split 16-bit instruction words into operand fields
// Assumes: fetch gives one word per cycle with its pc; no stall
// Notes: outputs register one cycle after the word is presented
`timescale 1ns/1ps
`default_nettype none
`include "ifd_defs.svh"
module ifd_decoder (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [31:0] instr_pc,
  input wire logic [1:0] op_size,
  output logic dec_valid,
  output ifd_pkg::ifd_fmt_e dec_fmt,
  output logic [15:0] dec_opcode,
  output logic [3:0] dec_rn,
  output logic [3:0] dec_rm,
  output logic dec_rn_used,
  output logic dec_rm_used,
  output logic dec_rn_write,
  output logic dec_dst_reg_zero,
  output logic dec_src_reg_zero,
  output logic dec_idx_r0,
  output logic dec_mac_ptrs,
  output logic [31:0] dec_imm,
  output logic [31:0] dec_disp,
  output logic [31:0] dec_branch_target
);
  ifd_pkg::ifd_state_s st_q;
  ifd_pkg::ifd_state_s st_d;

  // scale by operand size: 0 byte, 1 word, 2 long
  function automatic logic [31:0] scale(input logic [31:0] v, input logic [1:0] sz);
    case (sz)
      2'h1: scale = {v[30:0], 1'b0};
      2'h2: scale = {v[29:0], 2'h0};
      default: scale = v;
    endcase
  endfunction

  // coarse format from top nibble; a real table would be finer, this covers the shapes
  function automatic ifd_pkg::ifd_fmt_e classify(input logic [15:0] w);
    case (w[15:12])
      4'h0: classify = (w == `IFD_NOP_WORD) ? ifd_pkg::IFD_F_ZERO : ifd_pkg::IFD_F_NM;
      4'h4: classify = (w[3:0] == 4'hF) ? ifd_pkg::IFD_F_NM : ifd_pkg::IFD_F_N;
      4'h8: classify = (w[11:8] == 4'h0 || w[11:8] == 4'h4) ? ifd_pkg::IFD_F_ND4
                    : (w[11:8] == 4'h1 || w[11:8] == 4'h5) ? ifd_pkg::IFD_F_MD
                    : ifd_pkg::IFD_F_D;
      4'hA, 4'hB: classify = ifd_pkg::IFD_F_D12;
      4'h9, 4'hD: classify = ifd_pkg::IFD_F_ND8;
      4'hC: classify = ifd_pkg::IFD_F_I;
      4'h7, 4'hE: classify = ifd_pkg::IFD_F_NI;
      4'h1, 4'h5: classify = ifd_pkg::IFD_F_NM;
      default: classify = ifd_pkg::IFD_F_NM;
    endcase
  endfunction

  // extension kind for 8-bit immediates by opcode
  function automatic ifd_pkg::ifd_ext_e ext_kind(input logic [15:0] w);
    if (w[15:8] == 8'hC3) begin
      ext_kind = ifd_pkg::IFD_X_TRAP;
    end else if (w[15:12] == 4'hC) begin
      // the rest of this group are test, and, or, xor: a sign bit here would corrupt masks
      ext_kind = ifd_pkg::IFD_X_ZERO; // RULE_11
    end else begin
      ext_kind = ifd_pkg::IFD_X_SIGN;
    end
  endfunction

  // decode all fields from the presented word
  always_comb begin
    ifd_pkg::ifd_fmt_e f;
    ifd_pkg::ifd_ext_e x;
    f = classify(instr_word); // RULE_02
    x = ext_kind(instr_word);
    st_d = '0;
    st_d.valid = instr_valid;
    st_d.fmt = f;
    st_d.opcode = instr_word; // RULE_01
    case (f)
      ifd_pkg::IFD_F_ZERO: begin
        st_d.opcode = instr_word; // RULE_03
      end
      ifd_pkg::IFD_F_NM: begin
        st_d.opcode = {instr_word[15:12], 8'h00, instr_word[3:0]};
        st_d.rn = instr_word[`IFD_N_HI:`IFD_N_LO]; // RULE_14
        st_d.rm = instr_word[`IFD_M_HI:`IFD_M_LO]; // RULE_14
        st_d.rn_used = 1'b1;
        st_d.rm_used = 1'b1;
        if ((instr_word & `IFD_MACW_MASK) == `IFD_MACW_CODE) begin
          st_d.mac_ptrs = 1'b1; // RULE_07
          st_d.rn_write = 1'b0; // RULE_08
        end else begin
          st_d.rn_write = 1'b1;
        end
        st_d.idx_r0 = ((instr_word & `IFD_IDX_MASK) == `IFD_IDX_CODE); // RULE_06
      end
      ifd_pkg::IFD_F_N: begin
        st_d.opcode = {instr_word[15:12], 4'h0, instr_word[7:0]};
        st_d.rn = instr_word[`IFD_N_HI:`IFD_N_LO];
        st_d.rn_used = 1'b1;
        st_d.rn_write = 1'b1;
      end
      ifd_pkg::IFD_F_MD: begin
        st_d.opcode = {instr_word[15:8], 8'h00}; // RULE_04
        st_d.rm = instr_word[`IFD_M_HI:`IFD_M_LO]; // RULE_04
        st_d.rm_used = 1'b1;
        st_d.dst_reg_zero = 1'b1; // RULE_04
        st_d.disp = scale({28'h0, instr_word[`IFD_D4_HI:0]}, op_size); // RULE_10
      end
      ifd_pkg::IFD_F_ND4: begin
        st_d.opcode = {instr_word[15:8], 8'h00}; // RULE_05
        st_d.rn = instr_word[`IFD_M_HI:`IFD_M_LO]; // RULE_05
        st_d.rn_used = 1'b1;
        st_d.src_reg_zero = 1'b1; // RULE_05
        st_d.disp = scale({28'h0, instr_word[`IFD_D4_HI:0]}, op_size); // RULE_10
      end
      ifd_pkg::IFD_F_D, ifd_pkg::IFD_F_ND8: begin
        st_d.opcode = (f == ifd_pkg::IFD_F_D) ? {instr_word[15:8], 8'h00}
                                               : {instr_word[15:12], 12'h000};
        st_d.rn = (f == ifd_pkg::IFD_F_ND8) ? instr_word[`IFD_N_HI:`IFD_N_LO] : 4'h0; // RULE_13
        st_d.rn_used = (f == ifd_pkg::IFD_F_ND8);
        st_d.rn_write = (f == ifd_pkg::IFD_F_ND8);
        st_d.disp = scale({24'h0, instr_word[`IFD_D8_HI:0]}, op_size); // RULE_13 RULE_10
      end
      ifd_pkg::IFD_F_D12: begin
        st_d.opcode = {instr_word[15:12], 12'h000};
        st_d.disp = {20'h0, instr_word[`IFD_D12_HI:0]}; // RULE_09
        st_d.branch_target = instr_pc + {20'h0, instr_word[`IFD_D12_HI:0]}; // RULE_09
      end
      ifd_pkg::IFD_F_I, ifd_pkg::IFD_F_NI: begin
        st_d.opcode = (f == ifd_pkg::IFD_F_I) ? {instr_word[15:8], 8'h00}
                                               : {instr_word[15:12], 12'h000};
        st_d.rn = (f == ifd_pkg::IFD_F_NI) ? instr_word[`IFD_N_HI:`IFD_N_LO] : 4'h0; // RULE_13
        st_d.rn_used = (f == ifd_pkg::IFD_F_NI);
        st_d.rn_write = (f == ifd_pkg::IFD_F_NI);
        case (x)
          ifd_pkg::IFD_X_TRAP: st_d.imm = {22'h0, instr_word[7:0], 2'h0}; // RULE_12
          ifd_pkg::IFD_X_ZERO: st_d.imm = {24'h0, instr_word[7:0]}; // RULE_11
          default: st_d.imm = {{24{instr_word[7]}}, instr_word[7:0]}; // RULE_11
        endcase
      end
      default: begin
        st_d.opcode = instr_word;
      end
    endcase
  end

  // single state register; reset clears all decode outputs except dec_fmt, which loads IFD_F_ZERO
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= '{fmt: ifd_pkg::IFD_F_ZERO, default: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign dec_valid = st_q.valid;
  assign dec_fmt = st_q.fmt;
  assign dec_opcode = st_q.opcode;
  assign dec_rn = st_q.rn;
  assign dec_rm = st_q.rm;
  assign dec_rn_used = st_q.rn_used;
  assign dec_rm_used = st_q.rm_used;
  assign dec_rn_write = st_q.rn_write;
  assign dec_dst_reg_zero = st_q.dst_reg_zero;
  assign dec_src_reg_zero = st_q.src_reg_zero;
  assign dec_idx_r0 = st_q.idx_r0;
  assign dec_mac_ptrs = st_q.mac_ptrs;
  assign dec_imm = st_q.imm;
  assign dec_disp = st_q.disp;
  assign dec_branch_target = st_q.branch_target;

  a_nop_no_fields: assert property (@(posedge ref_clk) disable iff (rst) // RULE_03
    instr_word == `IFD_NOP_WORD |=> dec_opcode == `IFD_NOP_WORD && !dec_rn_used && !dec_rm_used)
    else $error("zero-operand word extracted a field");
  a_md_fields: assert property (@(posedge ref_clk) disable iff (rst) // RULE_04
    dec_fmt == ifd_pkg::IFD_F_MD |-> dec_dst_reg_zero && dec_rm == $past(instr_word[7:4]))
    else $error("md format fields wrong");
  a_nd4_fields: assert property (@(posedge ref_clk) disable iff (rst) // RULE_05
    dec_fmt == ifd_pkg::IFD_F_ND4 |-> dec_src_reg_zero && dec_rn == $past(instr_word[7:4]))
    else $error("nd4 format fields wrong");
  a_idx_reg_zero: assert property (@(posedge ref_clk) disable iff (rst) // RULE_06
    (instr_word & `IFD_IDX_MASK) == `IFD_IDX_CODE |=> dec_idx_r0)
    else $error("indexed mode not flagged");
  a_mac_pointers: assert property (@(posedge ref_clk) disable iff (rst) // RULE_07
    (instr_word & `IFD_MACW_MASK) == `IFD_MACW_CODE |=> dec_mac_ptrs && dec_rm_used)
    else $error("mac pointers not flagged");
  a_mac_no_write: assert property (@(posedge ref_clk) disable iff (rst) // RULE_08
    dec_mac_ptrs |-> !dec_rn_write)
    else $error("mac n register written");
  a_branch_target: assert property (@(posedge ref_clk) disable iff (rst) // RULE_09
    instr_word[15:12] == 4'hA
    |=> dec_branch_target == $past(instr_pc) + {20'h0, $past(instr_word[11:0])})
    else $error("branch target wrong");
  // both 4-bit displacement shapes scale the same way; a longword never has low bits set
  a_disp_scale: assert property (@(posedge ref_clk) disable iff (rst) // RULE_10
    $past(op_size) == 2'h2 && (dec_fmt == ifd_pkg::IFD_F_MD || dec_fmt == ifd_pkg::IFD_F_ND4)
    |-> dec_disp[1:0] == 2'h0 && dec_disp[31:6] == 26'h0)
    else $error("long displacement not scaled");
  // logic-op immediates must never carry a sign bit upward
  a_logic_imm_zero: assert property (@(posedge ref_clk) disable iff (rst) // RULE_11
    instr_word[15:12] == 4'hC && instr_word[11:8] != 4'h3 |=> dec_imm[31:8] == 24'h0)
    else $error("logic immediate not zero-extended");
  a_arith_imm_sign: assert property (@(posedge ref_clk) disable iff (rst) // RULE_11
    instr_word[15:12] == 4'h7
    |=> dec_imm == {{24{$past(instr_word[7])}}, $past(instr_word[7:0])})
    else $error("arithmetic immediate not sign-extended");
  a_nd8_fields: assert property (@(posedge ref_clk) disable iff (rst) // RULE_13
    dec_fmt == ifd_pkg::IFD_F_ND8 |-> dec_rn == $past(instr_word[11:8])
      && dec_disp[31:10] == 22'h0)
    else $error("nd8 register field wrong");
  a_branch_no_regs: assert property (@(posedge ref_clk) disable iff (rst) // RULE_01
    dec_fmt == ifd_pkg::IFD_F_D12 |-> !dec_rn_used && !dec_rm_used && dec_imm == 32'h0)
    else $error("branch format extracted a register");
  a_trap_offset: assert property (@(posedge ref_clk) disable iff (rst) // RULE_12
    instr_word[15:8] == 8'hC3 |=> dec_imm == {22'h0, $past(instr_word[7:0]), 2'h0})
    else $error("trap offset wrong");
  a_nm_fields: assert property (@(posedge ref_clk) disable iff (rst) // RULE_14
    dec_fmt == ifd_pkg::IFD_F_NM
    |-> dec_rn == $past(instr_word[11:8]) && dec_rm == $past(instr_word[7:4]))
    else $error("two-register fields wrong");
endmodule
`default_nettype wire

/* File: verif/ifd_fetch_model.sv */
// Purpose: fetch-side model that hands words to the field decoder
// Assumes: bench sets requests a fixed delay after the rising edge
// Notes: an idle word bus shows the inverse of the last word, never a held value
`timescale 1ns/1ps
`default_nettype none
module ifd_fetch_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [15:0] req_word,
  input wire logic [31:0] req_pc,
  input wire logic [1:0] req_size,
  output logic instr_valid,
  output logic [15:0] instr_word,
  output logic [31:0] instr_pc,
  output logic [1:0] op_size
);
  logic [15:0] last_q;
  // remember the last real word so idle cycles can show garbage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      last_q <= 16'h0000;
    end else if (req_valid) begin
      last_q <= req_word;
    end
  end
  // idle bus is not kind: decoder must rely on valid, not a stale word
  assign instr_valid = req_valid;
  assign instr_word = req_valid ? req_word : ~last_q;
  assign instr_pc = req_pc;
  assign op_size = req_size;
endmodule
`default_nettype wire

/* File: verif/ifd_decoder_bench.sv */
// Purpose: self-checking bench for the instruction field decoder
// Assumes: one word per cycle, one cycle decode latency
// Notes: rows run back to back; reset is checked before them and a mid-run reset case is hand-written after them
`timescale 1ns/1ps
`default_nettype none
module ifd_decoder_bench;
  typedef struct packed {
    logic [15:0] w;
    logic [31:0] pc;
    logic [1:0] sz;
    ifd_pkg::ifd_fmt_e fmt;
    logic [15:0] op;
    logic [3:0] rn;
    logic [3:0] rm;
    logic [2:0] k;
    logic [31:0] imm;
    logic [31:0] disp;
    logic [31:0] tgt;
    logic [3:0] fl;
  } ifd_row_s;
  // k: 0 none, 1 imm, 2 disp, 3 disp and target, 4 all zero; fl: dst0 src0 idx mac
  ifd_row_s rows [17] = '{
    '{16'h0009, 32'h0, 2'h0, ifd_pkg::IFD_F_ZERO, 16'h0009, 4'h0, 4'h0, 3'h4,
      32'h0, 32'h0, 32'h0, 4'h0},
    '{16'h0126, 32'h0, 2'h0, ifd_pkg::IFD_F_NM, 16'h0006, 4'h1, 4'h2, 3'h0,
      32'h0, 32'h0, 32'h0, 4'h2},
    '{16'h03A7, 32'h0, 2'h0, ifd_pkg::IFD_F_NM, 16'h0007, 4'h3, 4'hA, 3'h0,
      32'h0, 32'h0, 32'h0, 4'h0},
    '{16'h4A5F, 32'h0, 2'h0, ifd_pkg::IFD_F_NM, 16'h400F, 4'hA, 4'h5, 3'h0,
      32'h0, 32'h0, 32'h0, 4'h1},
    '{16'h4B2B, 32'h0, 2'h0, ifd_pkg::IFD_F_N, 16'h402B, 4'hB, 4'h0, 3'h0,
      32'h0, 32'h0, 32'h0, 4'h0},
    '{16'h8537, 32'h0, 2'h1, ifd_pkg::IFD_F_MD, 16'h8500, 4'h0, 4'h3, 3'h2,
      32'h0, 32'hE, 32'h0, 4'h8},
    '{16'h8537, 32'h0, 2'h3, ifd_pkg::IFD_F_MD, 16'h8500, 4'h0, 4'h3, 3'h2,
      32'h0, 32'h7, 32'h0, 4'h8},
    '{16'h8437, 32'h0, 2'h2, ifd_pkg::IFD_F_ND4, 16'h8400, 4'h3, 4'h0, 3'h2,
      32'h0, 32'h1C, 32'h0, 4'h4},
    '{16'h8437, 32'h0, 2'h0, ifd_pkg::IFD_F_ND4, 16'h8400, 4'h3, 4'h0, 3'h2,
      32'h0, 32'h7, 32'h0, 4'h4},
    '{16'hA800, 32'h100, 2'h0, ifd_pkg::IFD_F_D12, 16'hA000, 4'h0, 4'h0, 3'h3,
      32'h0, 32'h800, 32'h900, 4'h0},
    '{16'hBFFF, 32'h1000, 2'h2, ifd_pkg::IFD_F_D12, 16'hB000, 4'h0, 4'h0, 3'h3,
      32'h0, 32'hFFF, 32'h1FFF, 4'h0},
    '{16'hC3FF, 32'h0, 2'h0, ifd_pkg::IFD_F_I, 16'hC300, 4'h0, 4'h0, 3'h1,
      32'h3FC, 32'h0, 32'h0, 4'h0},
    '{16'hC8F0, 32'h0, 2'h0, ifd_pkg::IFD_F_I, 16'hC800, 4'h0, 4'h0, 3'h1,
      32'hF0, 32'h0, 32'h0, 4'h0},
    '{16'h7380, 32'h0, 2'h0, ifd_pkg::IFD_F_NI, 16'h7000, 4'h3, 4'h0, 3'h1,
      32'hFFFFFF80, 32'h0, 32'h0, 4'h0},
    '{16'hE17F, 32'h0, 2'h0, ifd_pkg::IFD_F_NI, 16'hE000, 4'h1, 4'h0, 3'h1,
      32'h7F, 32'h0, 32'h0, 4'h0},
    '{16'h8B12, 32'h0, 2'h1, ifd_pkg::IFD_F_D, 16'h8B00, 4'h0, 4'h0, 3'h2,
      32'h0, 32'h24, 32'h0, 4'h0},
    '{16'hD5C4, 32'h0, 2'h2, ifd_pkg::IFD_F_ND8, 16'hD000, 4'h5, 4'h0, 3'h2,
      32'h0, 32'h310, 32'h0, 4'h0}};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic [15:0] req_word = 16'h0000;
  logic [31:0] req_pc = 32'h00000000;
  logic [1:0] req_size = 2'h0;
  logic instr_valid, dec_valid, dec_rn_used, dec_rm_used, dec_rn_write, dec_dst_reg_zero;
  logic dec_src_reg_zero, dec_idx_r0, dec_mac_ptrs;
  logic [15:0] instr_word, dec_opcode;
  logic [31:0] instr_pc, dec_imm, dec_disp, dec_branch_target;
  logic [1:0] op_size;
  logic [3:0] dec_rn, dec_rm;
  ifd_pkg::ifd_fmt_e dec_fmt;
  int n_fail = 0;
  int check_count = 0;
  ifd_fetch_model fetch (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid),
    .req_word(req_word), .req_pc(req_pc), .req_size(req_size), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_pc(instr_pc), .op_size(op_size));
  ifd_decoder dut (.ref_clk(ref_clk), .rst(rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_pc(instr_pc), .op_size(op_size), .dec_valid(dec_valid),
    .dec_fmt(dec_fmt), .dec_opcode(dec_opcode), .dec_rn(dec_rn), .dec_rm(dec_rm),
    .dec_rn_used(dec_rn_used), .dec_rm_used(dec_rm_used), .dec_rn_write(dec_rn_write),
    .dec_dst_reg_zero(dec_dst_reg_zero), .dec_src_reg_zero(dec_src_reg_zero),
    .dec_idx_r0(dec_idx_r0), .dec_mac_ptrs(dec_mac_ptrs), .dec_imm(dec_imm),
    .dec_disp(dec_disp), .dec_branch_target(dec_branch_target));
  // 50 MHz clock
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // outputs after reset, also mid-run
  task automatic chk_reset();
    chk("valid", dec_valid, 32'h0);
    chk("fmt", dec_fmt, 32'h1);
    chk("opcode", dec_opcode, 32'h0);
    chk("rn", dec_rn, 32'h0);
    chk("imm", dec_imm, 32'h0);
    chk("target", dec_branch_target, 32'h0);
  endtask
  task automatic chk_row(input ifd_row_s r);
    chk("valid", dec_valid, 32'h1);
    chk("fmt", dec_fmt, r.fmt);
    chk("opcode", dec_opcode, r.op);
    chk("rn", dec_rn, r.rn);
    chk("rm", dec_rm, r.rm);
    chk("flags", {dec_dst_reg_zero, dec_src_reg_zero, dec_idx_r0, dec_mac_ptrs}, r.fl);
    chk("rn_used", dec_rn_used, r.fmt inside {ifd_pkg::IFD_F_NM, ifd_pkg::IFD_F_N,
      ifd_pkg::IFD_F_ND4, ifd_pkg::IFD_F_ND8, ifd_pkg::IFD_F_NI});
    chk("rm_used", dec_rm_used, r.fmt inside {ifd_pkg::IFD_F_NM, ifd_pkg::IFD_F_MD});
    chk("rn_write", dec_rn_write, !r.fl[0] && r.fmt inside {ifd_pkg::IFD_F_NM,
      ifd_pkg::IFD_F_N, ifd_pkg::IFD_F_ND8, ifd_pkg::IFD_F_NI});
    if (r.k == 3'h1 || r.k == 3'h4) chk("imm", dec_imm, r.imm);
    if (r.k >= 3'h2) chk("disp", dec_disp, r.disp);
    if (r.k >= 3'h3) chk("target", dec_branch_target, r.tgt);
  endtask
  task automatic drive(input ifd_row_s r);
    req_valid = 1'b1;
    req_word = r.w;
    req_pc = r.pc;
    req_size = r.sz;
  endtask
  // rows back to back, each checked one edge after it is presented
  initial begin
    repeat (5) @(posedge ref_clk);
    #2;
    chk_reset();
    rst = 1'b0;
    for (int i = 0; i <= 17; i++) begin
      @(posedge ref_clk);
      #2;
      if (i > 0) chk_row(rows[i-1]);
      if (i < 17) drive(rows[i]);
      else req_valid = 1'b0;
    end
    @(posedge ref_clk);
    #2;
    chk("valid idle", dec_valid, 32'h0);
    drive(rows[3]);
    @(posedge ref_clk);
    #2;
    rst = 1'b1;
    #1;
    chk_reset();
    @(posedge ref_clk);
    #2;
    rst = 1'b0;
    @(posedge ref_clk);
    #2;
    chk_row(rows[3]);
    report_and_stop();
  end
  // cut a hang short well past the expected run length
  initial begin
    #(20 * 500);
    n_fail++;
    report_and_stop();
  end
endmodule
`default_nettype wire
